// File: common/qbp_pkg.sv
// shared constants and carriers for the quasi-bidirectional port pair
package qbp_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  // strong pull-up pulse length in oscillator cycles
  localparam int PULSE_CYC = 2;
  localparam int PULSE_CNT_W = 2;
  // port 1 alternate function bit positions
  localparam int P1_TMR2_OUT = 0;
  localparam int P1_TMR2_CAP = 1;
  localparam int P1_SER1_RX = 2;
  localparam int P1_SER1_TX = 3;
  localparam int P1_IRQ2 = 4;
  localparam int P1_IRQ3 = 5;
  localparam int P1_IRQ4 = 6;
  localparam int P1_IRQ5 = 7;
  // port 3 alternate function bit positions
  localparam int P3_SER0_RX = 0;
  localparam int P3_SER0_TX = 1;
  localparam int P3_IRQ0 = 2;
  localparam int P3_IRQ1 = 3;
  localparam int P3_TMR0_CNT = 4;
  localparam int P3_TMR1_CNT = 5;
  localparam int P3_WR_STB = 6;
  localparam int P3_RD_STB = 7;

  // per-port pin drive: strong low, strong high, weak high
  typedef struct packed {
    logic [7:0] pull_down;
    logic [7:0] strong_up;
    logic [7:0] weak_up;
  } qbp_drive_s;

  // core access to one port
  typedef struct packed {
    logic byte_wr;
    logic [7:0] byte_data;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_data;
  } qbp_wr_s;

  // alternate-function outputs and their enables for port 1
  typedef struct packed {
    logic tmr_two_out;
    logic tmr_two_out_en;
    logic serial_one_tx_out;
    logic serial_one_tx_en;
  } qbp_p1_alt_s;

  // alternate-function outputs and their enables for port 3
  typedef struct packed {
    logic serial_zero_tx_out;
    logic serial_zero_tx_en;
    logic wr_strobe_n;
    logic wr_strobe_en;
    logic rd_strobe_n;
    logic rd_strobe_en;
  } qbp_p3_alt_s;
endpackage

// File: logic/qbp_port_pair.sv
// two quasi-bidirectional 8-bit ports with alternate functions
`timescale 1ns/1ps

// ----------------------------------------------------------------
// one port: latch, pull-up pulse timers, pin sampling
// ----------------------------------------------------------------
module qbp_port #(
  parameter int PULSE = qbp_pkg::PULSE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire qbp_pkg::qbp_wr_s wr_in,
  input wire logic [7:0] alt_en_in,
  input wire logic [7:0] alt_val_in,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_level_out,
  output logic [7:0] latch_out,
  output qbp_pkg::qbp_drive_s drive_out
);
  logic [7:0] latch_reg, latch_next;
  logic [7:0] sync1_reg, sync1_next;
  logic [7:0] sync2_reg, sync2_next;
  logic [7:0] eff_prev_reg, eff_prev_next;
  logic [qbp_pkg::PULSE_CNT_W-1:0] cnt_reg [8];
  logic [qbp_pkg::PULSE_CNT_W-1:0] cnt_next [8];
  logic [7:0] eff;

  always_comb begin
    latch_next = latch_reg;
    if (wr_in.byte_wr) begin
      latch_next = wr_in.byte_data;
    end else if (wr_in.bit_wr) begin
      latch_next[wr_in.bit_sel] = wr_in.bit_data;
    end
    // per-pin function routing, other pins untouched
    eff = (latch_reg & ~alt_en_in) | (latch_reg & alt_en_in & alt_val_in);
    sync1_next = pin_in;
    sync2_next = sync1_reg;
    eff_prev_next = eff;
    for (int i = 0; i < 8; i++) begin
      cnt_next[i] = (cnt_reg[i] != '0) ? cnt_reg[i] - 1'b1 : cnt_reg[i];
      if (eff[i] && !eff_prev_reg[i]) begin
        cnt_next[i] = qbp_pkg::PULSE_CNT_W'(PULSE);
      end else if (!eff[i]) begin
        cnt_next[i] = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      latch_reg <= qbp_pkg::LATCH_RESET;
      sync1_reg <= qbp_pkg::LATCH_RESET;
      sync2_reg <= qbp_pkg::LATCH_RESET;
      eff_prev_reg <= qbp_pkg::LATCH_RESET;
      for (int i = 0; i < 8; i++) begin
        cnt_reg[i] <= '0;
      end
    end else begin
      latch_reg <= latch_next;
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      eff_prev_reg <= eff_prev_next;
      for (int i = 0; i < 8; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drive_out.pull_down[i] = !eff_prev_reg[i];
      drive_out.strong_up[i] = eff_prev_reg[i] && (cnt_reg[i] != '0);
      drive_out.weak_up[i] = eff_prev_reg[i] && (cnt_reg[i] == '0);
    end
  end

  assign pin_level_out = sync2_reg;
  assign latch_out = latch_reg;
endmodule

// ----------------------------------------------------------------
// top: port 1 and port 3 with alternate functions
// ----------------------------------------------------------------
module qbp_port_pair #(
  parameter int PULSE = qbp_pkg::PULSE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire qbp_pkg::qbp_wr_s p1_wr_in,
  input wire qbp_pkg::qbp_wr_s p3_wr_in,
  input wire logic rmw_read_in,
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p3_pin_in,
  input wire qbp_pkg::qbp_p1_alt_s p1_alt_in,
  input wire qbp_pkg::qbp_p3_alt_s p3_alt_in,
  output logic [7:0] p1_read_out,
  output logic [7:0] p3_read_out,
  output qbp_pkg::qbp_drive_s p1_drive_out,
  output qbp_pkg::qbp_drive_s p3_drive_out,
  output logic tmr_two_capture_in_out,
  output logic serial_one_rx_in_out,
  output logic ext_irq_two_out,
  output logic ext_irq_three_out,
  output logic ext_irq_four_out,
  output logic ext_irq_five_out,
  output logic serial_zero_rx_in_out,
  output logic ext_irq_zero_out,
  output logic ext_irq_one_out,
  output logic tmr_zero_count_in_out,
  output logic tmr_one_count_in_out
);
  logic [7:0] p1_lvl, p3_lvl, p1_lat, p3_lat;
  logic [7:0] p1_en, p1_val, p3_en, p3_val;
  logic [7:0] p1_prev_reg, p1_prev_next, p3_prev_reg, p3_prev_next;
  logic [5:0] evt_reg, evt_next;

  // --------------------------------------------------------------
  // alternate-function drive
  // --------------------------------------------------------------
  always_comb begin
    p1_en = 8'h00;
    p1_val = 8'hFF;
    p3_en = 8'h00;
    p3_val = 8'hFF;
    p1_en[qbp_pkg::P1_TMR2_OUT] = p1_alt_in.tmr_two_out_en;
    p1_val[qbp_pkg::P1_TMR2_OUT] = p1_alt_in.tmr_two_out;
    p1_en[qbp_pkg::P1_SER1_TX] = p1_alt_in.serial_one_tx_en;
    p1_val[qbp_pkg::P1_SER1_TX] = p1_alt_in.serial_one_tx_out;
    p3_en[qbp_pkg::P3_SER0_TX] = p3_alt_in.serial_zero_tx_en;
    p3_val[qbp_pkg::P3_SER0_TX] = p3_alt_in.serial_zero_tx_out;
    p3_en[qbp_pkg::P3_WR_STB] = p3_alt_in.wr_strobe_en;
    p3_val[qbp_pkg::P3_WR_STB] = p3_alt_in.wr_strobe_n;
    p3_en[qbp_pkg::P3_RD_STB] = p3_alt_in.rd_strobe_en;
    p3_val[qbp_pkg::P3_RD_STB] = p3_alt_in.rd_strobe_n;
  end

  qbp_port #(.PULSE(PULSE)) u_p1 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(p1_wr_in),
    .alt_en_in(p1_en),
    .alt_val_in(p1_val),
    .pin_in(p1_pin_in),
    .pin_level_out(p1_lvl),
    .latch_out(p1_lat),
    .drive_out(p1_drive_out)
  );

  qbp_port #(.PULSE(PULSE)) u_p3 (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(p3_wr_in),
    .alt_en_in(p3_en),
    .alt_val_in(p3_val),
    .pin_in(p3_pin_in),
    .pin_level_out(p3_lvl),
    .latch_out(p3_lat),
    .drive_out(p3_drive_out)
  );

  // --------------------------------------------------------------
  // core read path
  // --------------------------------------------------------------
  // latch on read-modify-write
  assign p1_read_out = rmw_read_in ? p1_lat : p1_lvl;
  assign p3_read_out = rmw_read_in ? p3_lat : p3_lvl;

  // --------------------------------------------------------------
  // alternate inputs and edge detection
  // --------------------------------------------------------------
  always_comb begin
    p1_prev_next = p1_lvl;
    p3_prev_next = p3_lvl;
    evt_next[0] = p1_lvl[qbp_pkg::P1_IRQ2] & ~p1_prev_reg[qbp_pkg::P1_IRQ2];
    evt_next[1] = ~p1_lvl[qbp_pkg::P1_IRQ3] & p1_prev_reg[qbp_pkg::P1_IRQ3];
    evt_next[2] = p1_lvl[qbp_pkg::P1_IRQ4] & ~p1_prev_reg[qbp_pkg::P1_IRQ4];
    evt_next[3] = ~p1_lvl[qbp_pkg::P1_IRQ5] & p1_prev_reg[qbp_pkg::P1_IRQ5];
    evt_next[4] = ~p3_lvl[qbp_pkg::P3_IRQ0] & p3_prev_reg[qbp_pkg::P3_IRQ0];
    evt_next[5] = ~p3_lvl[qbp_pkg::P3_IRQ1] & p3_prev_reg[qbp_pkg::P3_IRQ1];
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      p1_prev_reg <= qbp_pkg::LATCH_RESET;
      p3_prev_reg <= qbp_pkg::LATCH_RESET;
      evt_reg <= 6'h00;
    end else begin
      p1_prev_reg <= p1_prev_next;
      p3_prev_reg <= p3_prev_next;
      evt_reg <= evt_next;
    end
  end

  assign ext_irq_two_out = evt_reg[0];
  assign ext_irq_three_out = evt_reg[1];
  assign ext_irq_four_out = evt_reg[2];
  assign ext_irq_five_out = evt_reg[3];
  assign ext_irq_zero_out = evt_reg[4];
  assign ext_irq_one_out = evt_reg[5];
  assign tmr_two_capture_in_out = p1_prev_reg[qbp_pkg::P1_TMR2_CAP];
  assign serial_one_rx_in_out = p1_prev_reg[qbp_pkg::P1_SER1_RX];
  assign serial_zero_rx_in_out = p3_prev_reg[qbp_pkg::P3_SER0_RX];
  assign tmr_zero_count_in_out = p3_prev_reg[qbp_pkg::P3_TMR0_CNT];
  assign tmr_one_count_in_out = p3_prev_reg[qbp_pkg::P3_TMR1_CNT];
endmodule

// File: bench/qbp_pin_load.sv
// behavioural load on one port: resolves each pin level
`timescale 1ns/1ps
module qbp_pin_load (
  input wire qbp_pkg::qbp_drive_s drive_in,
  input wire logic [7:0] force_en_in,
  input wire logic [7:0] force_val_in,
  output logic [7:0] pin_out
);
  // force beats pull-up
  // an unforced pin with no pull-down rests high, like the real pull-up
  assign pin_out = (force_en_in & force_val_in) |
    (~force_en_in & ~drive_in.pull_down);
endmodule

// File: bench/qbp_port_pair_sva.sv
// checker for the quasi-bidirectional port pair
`timescale 1ns/1ps
module qbp_port_pair_sva #(
  parameter int PULSE = 2
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire qbp_pkg::qbp_wr_s p1_wr_in,
  input wire logic rmw_read_in,
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p3_pin_in,
  input wire logic [7:0] p1_read_out,
  input wire qbp_pkg::qbp_drive_s p1_drive_out,
  input wire logic ext_irq_two_out,
  input wire logic ext_irq_three_out,
  input wire logic ext_irq_zero_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_weak_up: assert property (
    $rose(rst_n_in) |-> p1_drive_out == 24'h0000FF) else $error("reset drive");
  a_zero_pull_down: assert property (
    p1_wr_in.byte_wr && p1_wr_in.byte_data == 8'h00
    |=> ##1 p1_drive_out.pull_down == 8'hFF) else $error("no pull-down");
  a_pulse_two_cycles: assert property (
    $rose(p1_drive_out.strong_up[5]) |-> p1_drive_out.strong_up[5] [*2]
    ##1 p1_drive_out.weak_up[5]) else $error("pulse length");
  a_one_over_one: assert property (
    p1_wr_in.byte_wr && p1_wr_in.byte_data == 8'hFF &&
    !$past(p1_wr_in.byte_wr) && !$past(p1_wr_in.bit_wr) &&
    p1_drive_out == 24'h0000FF |=> ##1 p1_drive_out.strong_up == 8'h00)
    else $error("pulse on one over one");
  a_weak_up_hold: assert property (
    p1_drive_out.weak_up[2] && !p1_wr_in.byte_wr && !p1_wr_in.bit_wr &&
    !$past(p1_wr_in.byte_wr) && !$past(p1_wr_in.bit_wr)
    |=> p1_drive_out.weak_up[2]) else $error("weak pull-up dropped");
  a_pin_read: assert property (
    !rmw_read_in && $past(rst_n_in) && $past(rst_n_in, 2)
    |-> p1_read_out == $past(p1_pin_in, 2)) else $error("pin read");
  a_rmw_latch: assert property (
    rmw_read_in && $past(p1_wr_in.byte_wr)
    |-> p1_read_out == $past(p1_wr_in.byte_data)) else $error("latch read");
  a_irq_rise: assert property (
    $rose(p1_pin_in[4]) |-> ##3 ext_irq_two_out) else $error("irq two");
  a_irq_one_wide: assert property (
    ext_irq_three_out |=> !ext_irq_three_out) else $error("irq three wide");
  a_irq_fall: assert property (
    $fell(p3_pin_in[2]) |-> ##3 ext_irq_zero_out) else $error("irq zero");
  c_pulse: cover property (p1_drive_out.strong_up != 8'h00);
  c_irq: cover property (ext_irq_two_out);
  c_bit_rmw: cover property (rmw_read_in && p1_wr_in.bit_wr);
endmodule
bind qbp_port_pair qbp_port_pair_sva #(.PULSE(PULSE)) qbp_port_pair_sva_i (
  .sys_clk_in, .rst_n_in, .p1_wr_in, .rmw_read_in, .p1_pin_in, .p3_pin_in,
  .p1_read_out, .p1_drive_out, .ext_irq_two_out, .ext_irq_three_out,
  .ext_irq_zero_out);

// File: bench/qbp_port_pair_bench.sv
// self-checking bench for the quasi-bidirectional port pair
`timescale 1ns/1ps
module qbp_port_pair_bench;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rmw = 1'b0;
  qbp_pkg::qbp_wr_s p1_wr = '0;
  qbp_pkg::qbp_wr_s p3_wr = '0;
  qbp_pkg::qbp_drive_s p1_drv, p3_drv;
  logic [7:0] p1_pin, p3_pin, p1_rd, p3_rd;
  logic [7:0] p1_xen = 8'h00, p1_xval = 8'h00, p3_xen = 8'h00;
  qbp_pkg::qbp_p1_alt_s p1_alt = '0;
  qbp_pkg::qbp_p3_alt_s p3_alt = '0;
  wire [5:0] irq;
  wire [4:0] rx;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  qbp_port_pair qbp_port_pair_i (
    .sys_clk_in, .rst_n_in, .p1_wr_in(p1_wr), .p3_wr_in(p3_wr),
    .rmw_read_in(rmw), .p1_pin_in(p1_pin), .p3_pin_in(p3_pin),
    .p1_alt_in(p1_alt), .p3_alt_in(p3_alt), .p1_read_out(p1_rd),
    .p3_read_out(p3_rd), .p1_drive_out(p1_drv), .p3_drive_out(p3_drv),
    .tmr_two_capture_in_out(rx[0]), .serial_one_rx_in_out(rx[1]),
    .ext_irq_two_out(irq[0]), .ext_irq_three_out(irq[1]),
    .ext_irq_four_out(irq[2]), .ext_irq_five_out(irq[3]),
    .serial_zero_rx_in_out(rx[2]), .ext_irq_zero_out(irq[4]),
    .ext_irq_one_out(irq[5]), .tmr_zero_count_in_out(rx[3]),
    .tmr_one_count_in_out(rx[4]));
  qbp_pin_load qbp_pin_load_i (.drive_in(p1_drv), .force_en_in(p1_xen),
    .force_val_in(p1_xval), .pin_out(p1_pin));
  qbp_pin_load qbp_pin_load_p3_i (.drive_in(p3_drv), .force_en_in(p3_xen),
    .force_val_in(8'h00), .pin_out(p3_pin));
  task automatic check(input string what, input logic [23:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // strobe stands one edge; the idle edge after it lets the drive follow
  task automatic wr(input bit p3, bw, input logic [7:0] d, input logic [2:0] s);
    qbp_pkg::qbp_wr_s w;
    w = '{byte_wr: bw, byte_data: d, bit_wr: !bw, bit_sel: s, bit_data: d[0]};
    if (p3) p3_wr = w;
    else p1_wr = w;
    tick(1);
    p1_wr = '0;
    p3_wr = '0;
    tick(1);
  endtask
  task automatic t_reset();
    rmw = 1'b1;
    #1;
    check("p1 drive", p1_drv, 24'h0000FF);
    check("p3 drive", p3_drv, 24'h0000FF);
    check("latches", {p1_rd, p3_rd}, 24'h00FFFF);
  endtask
  task automatic t_walk();
    wr(0, 1, 8'h00, 3'h0);
    check("pull down", p1_drv, 24'hFF0000);
    tick(3);
    check("held low", p1_drv, 24'hFF0000);
    wr(0, 1, 8'hFF, 3'h0);
    check("pulse one", p1_drv, 24'h00FF00);
    tick(1);
    check("pulse two", p1_drv, 24'h00FF00);
    tick(1);
    check("weak", p1_drv, 24'h0000FF);
    wr(0, 1, 8'hFF, 3'h0);
    check("no pulse", p1_drv, 24'h0000FF);
  endtask
  task automatic t_bits();
    wr(0, 0, 8'h00, 3'h5);
    check("bit latch", p1_rd, 8'hDF);
    check("bit drive", p1_drv, 24'h2000DF);
    wr(0, 0, 8'h01, 3'h5);
    check("bit pulse", p1_drv, 24'h0020DF);
  endtask
  task automatic t_pins();
    rmw = 1'b0;
    p3_xen = 8'h01;
    tick(2);
    check("pin read", p3_rd, 8'hFE);
    rmw = 1'b1;
    #1;
    check("latch read", p3_rd, 8'hFF);
    tick(1);
    check("serial zero rx", rx[2], 1'b0);
    rmw = 1'b0;
    p3_xen = 8'h00;
    tick(2);
    check("pin back", p3_rd, 8'hFF);
  endtask
  task automatic t_irq();
    p1_xen = 8'hFF;
    p3_xen = 8'h0C;
    tick(3);
    check("falling irqs", irq, 6'h3A);
    check("timer and rx in", rx[1:0], 2'b00);
    tick(1);
    check("irq width", irq, 6'h00);
    p1_xval = 8'hFF;
    p3_xen = 8'h00;
    tick(3);
    check("rising irqs", irq, 6'h05);
    p1_xen = 8'h00;
  endtask
  task automatic t_alt();
    wr(0, 1, 8'hFF, 3'h0);
    wr(1, 1, 8'hFF, 3'h0);
    // p1: timer-two and serial-one tx driven low
    p1_alt = 4'h5;
    // p3: tx and read strobe high, write strobe low
    p3_alt = 6'h37;
    p3_xen = 8'h30;
    tick(1);
    check("p1 alt low", p1_drv, 24'h0900F6);
    check("p3 alt low", p3_drv, 24'h4000BF);
    p1_alt = 4'hF;
    p3_alt = 6'h3F;
    tick(1);
    check("p1 alt pulse", p1_drv, 24'h0009F6);
    check("p3 alt pulse", p3_drv, 24'h0040BF);
    tick(1);
    check("timer counts in", rx[4:3], 2'b00);
    rmw = 1'b1;
    #1;
    check("alt latches", {p1_rd, p3_rd}, 16'hFFFF);
    p1_alt = '0;
    p3_alt = '0;
    p3_xen = 8'h00;
    tick(2);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    t_reset();
    t_walk();
    t_bits();
    t_pins();
    t_irq();
    t_alt();
    tick(2);
    complete_run();
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 500) begin
      n_mismatch++;
      complete_run();
    end
  end
endmodule
